// *** common/sctpwm_pkg.sv ***
// Constants and carrier types for the sixteen channel modulator
package sctpwm_pkg;
	localparam int          PADDR_W          = 18;
	localparam int          NUM_CH           = 16;
	localparam int          CNT_W            = 8;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_DUTY_BASE    = 16'hfff0;
	localparam logic [15:0] IDX_POL_LO       = 16'hffcf;
	localparam logic [15:0] IDX_POL_HI       = 16'hffce;
	localparam logic [15:0] IDX_OE_LO        = 16'hffd5;
	localparam logic [15:0] IDX_OE_HI        = 16'hffcd;
	localparam logic [15:0] IDX_DIR_A        = 16'hffb0;
	localparam logic [15:0] IDX_DIR_B        = 16'hffb1;
	localparam logic [15:0] IDX_LVL_A        = 16'hffb2;
	localparam logic [15:0] IDX_LVL_B        = 16'hffb3;
	localparam logic [15:0] IDX_CTRL         = 16'hffc3;
	// Shared control register fields
	localparam int          CTRL_TWO_WIRE_HI = 7;
	localparam int          CTRL_TWO_WIRE_LO = 5;
	localparam int          CTRL_SYNC_GATE   = 4;
	localparam int          CTRL_CLK_GATE    = 3;
	localparam int          CTRL_CLK_CHOICE  = 2;
	localparam int          CTRL_BYTE_HI     = 1;
	localparam int          CTRL_BYTE_LO     = 0;
	localparam logic [7:0]  REG8_RESET       = 8'h00;
	localparam logic [15:0] REG16_RESET      = 16'h0000;
	localparam logic [7:0]  CNT_RESET        = 8'h00;
	localparam logic [3:0]  LAST_SLOT        = 4'hf;
	// Timing
	localparam int          CLK_PERIOD_NS    = 25;
	localparam int          PCLK_DIVIDE      = 2;
	localparam int          RES_SLOW_CYCLES  = PCLK_DIVIDE;
	localparam int          PERIOD_SLOTS     = 256;

	typedef struct packed
	{
		logic [15:0] level;
		logic [15:0] drive_en;
	} sctpwm_pins_t;
endpackage

// *** logic/sctpwm_top.sv ***
// Sixteen channel pulse width modulator with APB registers
`timescale 1ns/1ps

module sctpwm_top
(
	input  wire logic                              i_clk,
	input  wire logic                              i_rst_n,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [sctpwm_pkg::PADDR_W-1:0]    paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              i_hw_standby,
	input  wire logic                              i_sw_standby,
	input  wire logic                              i_host_interface_gate,
	input  wire logic [sctpwm_pkg::NUM_CH-1:0]     i_pin_in,
	output sctpwm_pkg::sctpwm_pins_t               o_pins,
	output logic      [2:0]                        o_two_wire_ctrl,
	output logic                                   o_interconnect_output_gate,
	output logic      [1:0]                        o_byte_timer_clock_sel
);
	logic [7:0]  duty [sctpwm_pkg::NUM_CH];
	logic [15:0] pol;
	logic [15:0] oe;
	logic [15:0] dir;
	logic [15:0] lvl;
	logic [7:0]  ctrl;
	logic [7:0]  shared_counter;
	logic        half_phase;
	logic [15:0] pin_level;
	logic [31:0] rdata;

	// Bus decode
	wire         setup_rd    = psel & ~penable & ~pwrite;
	wire         access      = psel & penable;
	wire [15:0]  idx         = paddr[17:2];
	wire         hit_duty    = (idx[15:4] == sctpwm_pkg::IDX_DUTY_BASE[15:4]);
	wire         duty_ok     = hit_duty & ~i_host_interface_gate;
	wire         hit_pol_lo  = (idx == sctpwm_pkg::IDX_POL_LO);
	wire         hit_pol_hi  = (idx == sctpwm_pkg::IDX_POL_HI);
	wire         hit_oe_lo   = (idx == sctpwm_pkg::IDX_OE_LO);
	wire         hit_oe_hi   = (idx == sctpwm_pkg::IDX_OE_HI);
	wire         hit_dir_a   = (idx == sctpwm_pkg::IDX_DIR_A);
	wire         hit_dir_b   = (idx == sctpwm_pkg::IDX_DIR_B);
	wire         hit_lvl_a   = (idx == sctpwm_pkg::IDX_LVL_A);
	wire         hit_lvl_b   = (idx == sctpwm_pkg::IDX_LVL_B);
	wire         hit_ctrl    = (idx == sctpwm_pkg::IDX_CTRL);
	wire         mapped      = duty_ok | hit_pol_lo | hit_pol_hi | hit_oe_lo | hit_oe_hi
	                         | hit_dir_a | hit_dir_b | hit_lvl_a | hit_lvl_b | hit_ctrl;
	wire         wr          = access & pwrite & mapped;
	wire [7:0]   wbyte       = pwdata[7:0];
	wire [3:0]   duty_sel    = idx[3:0];

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// Port level reads show pin for input bits
	wire [15:0]  lvl_view    = (dir & lvl) | (~dir & i_pin_in);
	wire [7:0]   rd_byte     = duty_ok    ? duty[duty_sel] :
	                           hit_pol_lo ? pol[7:0] :
	                           hit_pol_hi ? pol[15:8] :
	                           hit_oe_lo  ? oe[7:0] :
	                           hit_oe_hi  ? oe[15:8] :
	                           hit_lvl_a  ? lvl_view[7:0] :
	                           hit_lvl_b  ? lvl_view[15:8] :
	                           hit_ctrl   ? ctrl : 8'h00;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rdata <= 32'h0000_0000;
		else if (setup_rd)
			rdata <= {24'h00_0000, rd_byte};
	end
	assign prdata = rdata;

	// Polarity, enable, direction, level, control
	wire         any_standby = i_hw_standby | i_sw_standby;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pol <= sctpwm_pkg::REG16_RESET;
			oe  <= sctpwm_pkg::REG16_RESET;
		end
		else if (i_hw_standby)
		begin
			pol <= sctpwm_pkg::REG16_RESET;
			oe  <= sctpwm_pkg::REG16_RESET;
		end
		else if (wr)
		begin
			if (hit_pol_lo)
				pol[7:0] <= wbyte;
			if (hit_pol_hi)
				pol[15:8] <= wbyte;
			if (hit_oe_lo)
				oe[7:0] <= wbyte;
			if (hit_oe_hi)
				oe[15:8] <= wbyte;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			dir  <= sctpwm_pkg::REG16_RESET;
			lvl  <= sctpwm_pkg::REG16_RESET;
			ctrl <= sctpwm_pkg::REG8_RESET;
		end
		else if (wr)
		begin
			if (hit_dir_a)
				dir[7:0] <= wbyte;
			if (hit_dir_b)
				dir[15:8] <= wbyte;
			if (hit_lvl_a)
				lvl[7:0] <= wbyte;
			if (hit_lvl_b)
				lvl[15:8] <= wbyte;
			if (hit_ctrl)
				ctrl <= wbyte;
		end
	end

	// Neighbour control bits only
	assign o_two_wire_ctrl            = ctrl[sctpwm_pkg::CTRL_TWO_WIRE_HI:sctpwm_pkg::CTRL_TWO_WIRE_LO];
	assign o_interconnect_output_gate = ctrl[sctpwm_pkg::CTRL_SYNC_GATE];
	assign o_byte_timer_clock_sel     = ctrl[sctpwm_pkg::CTRL_BYTE_HI:sctpwm_pkg::CTRL_BYTE_LO];

	// Counter clock selection
	wire         clk_gate    = ctrl[sctpwm_pkg::CTRL_CLK_GATE];
	wire         clk_choice  = ctrl[sctpwm_pkg::CTRL_CLK_CHOICE];
	wire         tick        = clk_gate & (~clk_choice | half_phase);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			half_phase <= 1'b0;
		else
			half_phase <= ~half_phase;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			shared_counter <= sctpwm_pkg::CNT_RESET;
		else if (i_hw_standby)
			shared_counter <= sctpwm_pkg::CNT_RESET;
		else if (tick)
			shared_counter <= shared_counter + 8'h01;
	end

	wire [3:0]   slot        = shared_counter[3:0];
	wire [3:0]   pulse_no    = shared_counter[7:4];
	// Rank of this pulse in the spreading order
	wire [3:0]   rank        = {~pulse_no[0], ~pulse_no[1], ~pulse_no[2], ~pulse_no[3]};

	// Channels
	genvar g;
	generate
		for (g = 0; g < sctpwm_pkg::NUM_CH; g++)
		begin : g_ch
			wire basic     = (slot < duty[g][7:4]);
			wire extra     = (slot == sctpwm_pkg::LAST_SLOT) && (rank < duty[g][3:0]);
			wire modulated = (basic | extra) ^ pol[g];
			wire next_pin  = oe[g] ? modulated : lvl[g];

			always_ff @(posedge i_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					duty[g] <= sctpwm_pkg::REG8_RESET;
				else if (any_standby)
					duty[g] <= sctpwm_pkg::REG8_RESET;
				else if (wr && duty_ok && duty_sel == 4'(g))
					duty[g] <= wbyte;
			end

			always_ff @(posedge i_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					pin_level[g] <= 1'b0;
				else
					pin_level[g] <= next_pin;
			end
		end
	endgenerate

	assign o_pins.level    = pin_level;
	assign o_pins.drive_en = dir;

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	wire [15:0]  duty_or;
	wire [127:0] duty_flat;
	generate
		for (g = 0; g < sctpwm_pkg::NUM_CH; g++)
		begin : g_chk
			assign duty_or[g]          = |duty[g];
			assign duty_flat[g*8 +: 8] = duty[g];

			basic_high_a: assert property (oe[g] && !pol[g] && slot < duty[g][7:4]
				|=> o_pins.level[g])
				else $error("basic pulse not high");
			inv_low_a: assert property (oe[g] && pol[g] && slot < duty[g][7:4]
				|=> !o_pins.level[g])
				else $error("inverted basic pulse not low");
			extra_all_a: assert property (oe[g] && !pol[g] && slot == sctpwm_pkg::LAST_SLOT
				&& duty[g][3:0] == 4'hf && pulse_no != 4'h0 |=> o_pins.level[g])
				else $error("extra pulse missing");
			no_extra_a: assert property (oe[g] && !pol[g] && slot == sctpwm_pkg::LAST_SLOT
				&& duty[g][3:0] == 4'h0 |=> !o_pins.level[g])
				else $error("extra pulse without count");
			first_extra_a: assert property (oe[g] && !pol[g] && slot == sctpwm_pkg::LAST_SLOT
				&& duty[g][3:0] == 4'h1 |=> o_pins.level[g] == ($past(pulse_no) == 4'hf))
				else $error("single extra pulse misplaced");
			zero_basic_a: assert property (oe[g] && !pol[g] && duty[g][7:4] == 4'h0
				&& slot != sctpwm_pkg::LAST_SLOT |=> !o_pins.level[g])
				else $error("pulse outside extra slot");
			port_hold_a: assert property (!oe[g]
				|=> o_pins.level[g] == $past(lvl[g]))
				else $error("port mode pin not at level bit");
			full_guard_a: assert property (oe[g] && !pol[g] && shared_counter == 8'h0f
				|=> !o_pins.level[g])
				else $error("modulator reached full level");
			empty_guard_a: assert property (oe[g] && pol[g] && shared_counter == 8'h0f
				|=> o_pins.level[g])
				else $error("inverted output reached zero level");
		end
	endgenerate

	duty_standby_clear_a: assert property (any_standby |=> duty_or == 16'h0000)
		else $error("duty not cleared by standby");
	pol_hw_clear_a: assert property (i_hw_standby |=> pol == 16'h0000)
		else $error("polarity not cleared by hardware standby");
	oe_hw_clear_a: assert property (i_hw_standby |=> oe == 16'h0000)
		else $error("enable not cleared by hardware standby");
	dir_input_a: assert property (wr && hit_dir_b && !wbyte[0] |=> !o_pins.drive_en[8])
		else $error("pin 8 still driven after direction cleared");
	port_level_a: assert property (!oe[0] |=> o_pins.level[0] == $past(lvl[0]))
		else $error("port mode pin does not follow level bit");
	never_full_a: assert property (oe[0] && !pol[0] && shared_counter == 8'h0f
		|=> !o_pins.level[0])
		else $error("modulator reached full level");
	zero_duty_a: assert property (oe[1] && !pol[1] && duty[1] == 8'h00
		|=> !o_pins.level[1])
		else $error("zero duty output high");
	clk_stop_a: assert property (!clk_gate && !i_hw_standby |=> $stable(shared_counter))
		else $error("counter moved with clock gated");
	half_rate_a: assert property (clk_gate && clk_choice && tick
		|=> !tick ##1 (tick || !clk_gate || !clk_choice))
		else $error("half rate tick spacing wrong");
	host_block_a: assert property (access && hit_duty && i_host_interface_gate
		|-> pslverr)
		else $error("duty access not refused");
	ctrl_pass_a: assert property (wr && hit_ctrl
		|=> o_two_wire_ctrl == $past(wbyte[7:5]))
		else $error("control bits not passed on");

	// Register file
	read_upper_a: assert property (setup_rd
		|=> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	dir_a_read_a: assert property (setup_rd && hit_dir_a
		|=> prdata == 32'h0000_0000)
		else $error("direction A readable");
	dir_b_read_a: assert property (setup_rd && hit_dir_b
		|=> prdata == 32'h0000_0000)
		else $error("direction B readable");
	ctrl_read_a: assert property (setup_rd && hit_ctrl
		|=> prdata[7:0] == $past(ctrl))
		else $error("control read wrong");
	duty_read_a: assert property (setup_rd && duty_ok && !any_standby
		|=> prdata[7:0] == duty[$past(duty_sel)])
		else $error("duty read wrong");
	host_read_a: assert property (setup_rd && hit_duty && i_host_interface_gate
		|=> prdata == 32'h0000_0000)
		else $error("blocked duty read not zero");
	host_write_a: assert property (access && pwrite && hit_duty && i_host_interface_gate
		&& !any_standby |=> $stable(duty_flat))
		else $error("blocked duty write landed");
	duty_write_a: assert property (wr && duty_ok && !any_standby
		|=> duty[$past(duty_sel)] == $past(wbyte))
		else $error("duty write lost");
	pol_lo_write_a: assert property (wr && hit_pol_lo && !i_hw_standby
		|=> pol[7:0] == $past(wbyte))
		else $error("polarity low write lost");
	pol_hi_write_a: assert property (wr && hit_pol_hi && !i_hw_standby
		|=> pol[15:8] == $past(wbyte))
		else $error("polarity high write lost");
	oe_lo_write_a: assert property (wr && hit_oe_lo && !i_hw_standby
		|=> oe[7:0] == $past(wbyte))
		else $error("enable low write lost");
	oe_hi_write_a: assert property (wr && hit_oe_hi && !i_hw_standby
		|=> oe[15:8] == $past(wbyte))
		else $error("enable high write lost");
	dir_a_drive_a: assert property (wr && hit_dir_a
		|=> o_pins.drive_en[7:0] == $past(wbyte))
		else $error("direction A does not drive pins 0 to 7");
	dir_b_drive_a: assert property (wr && hit_dir_b
		|=> o_pins.drive_en[15:8] == $past(wbyte))
		else $error("direction B does not drive pins 8 to 15");
	lvl_b_write_a: assert property (wr && hit_lvl_b
		|=> lvl[15:8] == $past(wbyte))
		else $error("level B write lost");
	ctrl_write_a: assert property (wr && hit_ctrl
		|=> ctrl == $past(wbyte))
		else $error("control write lost");
	port_view_a: assert property (setup_rd && hit_lvl_a
		|=> prdata[7:0] == $past((dir[7:0] & lvl[7:0]) | (~dir[7:0] & i_pin_in[7:0])))
		else $error("port A read view wrong");
	sync_pass_a: assert property (wr && hit_ctrl
		|=> o_interconnect_output_gate == $past(wbyte[4]))
		else $error("interconnect gate not passed on");
	byte_pass_a: assert property (wr && hit_ctrl
		|=> o_byte_timer_clock_sel == $past(wbyte[1:0]))
		else $error("byte timer select not passed on");
	err_access_a: assert property (pslverr
		|-> access)
		else $error("error outside access phase");
	no_err_a: assert property (access && mapped
		|-> !pslverr)
		else $error("error on mapped access");
	sw_pol_keep_a: assert property (i_sw_standby && !i_hw_standby && !wr
		|=> $stable(pol))
		else $error("software standby changed polarity");

	// Counter
	counter_clear_a: assert property (i_hw_standby
		|=> shared_counter == sctpwm_pkg::CNT_RESET)
		else $error("counter not cleared by hardware standby");
	full_rate_a: assert property (clk_gate && !clk_choice && !i_hw_standby
		|=> shared_counter == $past(shared_counter) + 8'h01)
		else $error("full rate counter did not step");
	half_step_a: assert property (clk_gate && clk_choice && tick && !i_hw_standby
		|=> shared_counter == $past(shared_counter) + 8'h01)
		else $error("half rate counter did not step");

	wrap_cov_c: cover property (tick && shared_counter == 8'hff);
	half_run_c: cover property (clk_gate && clk_choice && tick);
	port_mode_c: cover property (dir[0] && !oe[0] && lvl[0]);
	duty_write_c: cover property (wr && duty_ok);
	extra_slot_c: cover property (tick && slot == sctpwm_pkg::LAST_SLOT && rank == 4'h0);
endmodule

// *** sim/sctpwm_load.sv ***
// Pin loads: resolves each pin wire from the drive enables
`timescale 1ns/1ps
module sctpwm_load
(
	input  wire logic                     i_clk,
	input  wire sctpwm_pkg::sctpwm_pins_t i_pins,
	output logic      [15:0]              o_pin_in
);
	logic [15:0] ext = 16'h5a5a;
	// Undriven pins toggle so a stale value never looks valid
	always_ff @(posedge i_clk)
		ext <= ~ext;
	assign o_pin_in = (i_pins.drive_en & i_pins.level) | (~i_pins.drive_en & ext);
endmodule

// *** sim/sixteen_channel_pwm_timer_bench.sv ***
// Self-checking bench for the sixteen channel modulator
`timescale 1ns/1ps
module sixteen_channel_pwm_timer_bench;
	logic                     i_clk = 1'b0;
	logic                     i_rst_n = 1'b0;
	logic                     psel = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite = 1'b0;
	logic [17:0]              paddr = 18'h00000;
	logic [31:0]              pwdata = 32'h00000000;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     hw_sb = 1'b0;
	logic                     sw_sb = 1'b0;
	logic                     gate = 1'b0;
	logic [15:0]              pin_in;
	sctpwm_pkg::sctpwm_pins_t pins;
	logic [2:0]               tw;
	logic                     sg;
	logic [1:0]               bt;
	logic [31:0]              rd;
	logic                     er;
	integer                   fail_count = 0;
	integer                   check_count = 0;
	integer                   seed = 32'h646dc4a6;
	integer                   duty[16];
	integer                   hc[16];
	integer                   i;
	integer                   k;
	logic [15:0]              pol;
	logic [15:0]              oe;
	logic [15:0]              dir;
	logic [15:0]              lvl;
	logic [15:0]              ridx[6];

	sctpwm_top i_sctpwm_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .i_hw_standby(hw_sb), .i_sw_standby(sw_sb),
		.i_host_interface_gate(gate), .i_pin_in(pin_in), .o_pins(pins),
		.o_two_wire_ctrl(tw), .o_interconnect_output_gate(sg), .o_byte_timer_clock_sel(bt));
	sctpwm_load i_sctpwm_load (.i_clk(i_clk), .i_pins(pins), .o_pin_in(pin_in));

	initial
		forever #12.5 i_clk = ~i_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge i_clk);
		penable <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1)
			@(posedge i_clk);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [15:0] idx, input integer exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask

	task automatic note(input string s);
		$display("test %s done", s);
	endtask

	task automatic sb(input logic hw);
		@(posedge i_clk);
		hw_sb <= hw;
		sw_sb <= ~hw;
		@(posedge i_clk);
		hw_sb <= 1'b0;
		sw_sb <= 1'b0;
	endtask

	task automatic cfg();
		pol = 16'($random(seed));
		oe = 16'($random(seed));
		dir = 16'($random(seed));
		lvl = 16'($random(seed));
		for (i = 0; i < 16; i++)
			duty[i] = $random(seed) & 255;
		duty[0] = 0;
		duty[1] = 255;
		duty[2] = 15;
		for (i = 0; i < 16; i++)
			apb(1'b1, sctpwm_pkg::IDX_DUTY_BASE + 16'(i), duty[i][7:0]);
		apb(1'b1, sctpwm_pkg::IDX_POL_LO, pol[7:0]);
		apb(1'b1, sctpwm_pkg::IDX_POL_HI, pol[15:8]);
		apb(1'b1, sctpwm_pkg::IDX_OE_LO, oe[7:0]);
		apb(1'b1, sctpwm_pkg::IDX_OE_HI, oe[15:8]);
		apb(1'b1, sctpwm_pkg::IDX_DIR_A, dir[7:0]);
		apb(1'b1, sctpwm_pkg::IDX_DIR_B, dir[15:8]);
		apb(1'b1, sctpwm_pkg::IDX_LVL_A, lvl[7:0]);
		apb(1'b1, sctpwm_pkg::IDX_LVL_B, lvl[15:8]);
	endtask

	// Reference level of all pins for one counter value
	function automatic logic [15:0] lvl_exp(input integer c);
		integer s;
		integer p;
		integer r;
		integer ch;
		logic   h;
		s = c % 16;
		p = 15 - (c / 16) % 16;
		r = {p[0], p[1], p[2], p[3]};
		for (ch = 0; ch < 16; ch++)
		begin
			h = (s < duty[ch] / 16) || (s == 15 && r < duty[ch] % 16);
			lvl_exp[ch] = oe[ch] ? h ^ pol[ch] : lvl[ch];
		end
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#1000000;
		fail_count++;
		print_verdict();
	end

	initial
	begin
		ridx = '{sctpwm_pkg::IDX_POL_LO, sctpwm_pkg::IDX_POL_HI, sctpwm_pkg::IDX_OE_LO,
			sctpwm_pkg::IDX_OE_HI, sctpwm_pkg::IDX_DIR_A, sctpwm_pkg::IDX_CTRL};
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (i = 0; i < 16; i++)
			rchk(sctpwm_pkg::IDX_DUTY_BASE + 16'(i), 0);
		for (i = 0; i < 6; i++)
			rchk(ridx[i], 0);
		note("reset");
		apb(1'b1, sctpwm_pkg::IDX_CTRL, 8'hf3);
		rchk(sctpwm_pkg::IDX_CTRL, 32'hf3);
		chk({26'h0, tw, sg, bt}, 32'h3f);
		gate <= 1'b1;
		apb(1'b1, sctpwm_pkg::IDX_DUTY_BASE + 16'h3, 8'h55);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 16'hff00, 8'h00);
		chk({31'h0, er}, 32'h1);
		gate <= 1'b0;
		rchk(sctpwm_pkg::IDX_DUTY_BASE + 16'h3, 0);
		note("access");
		sb(1'b1);
		cfg();
		for (k = 0; k < 20; k++)
		begin
			@(posedge i_clk);
			#1 chk(pins.level, lvl_exp(0));
		end
		apb(1'b1, sctpwm_pkg::IDX_CTRL, 8'h08);
		for (k = 1; k <= 256; k++)
		begin
			@(posedge i_clk);
			#1 chk(pins.level, lvl_exp(k - 1));
			chk(pins.drive_en, dir);
		end
		note("full rate");
		apb(1'b1, sctpwm_pkg::IDX_CTRL, 8'h0c);
		repeat (4) @(posedge i_clk);
		for (i = 0; i < 16; i++)
			hc[i] = 0;
		repeat (512)
		begin
			@(posedge i_clk);
			#1 for (i = 0; i < 16; i++)
				hc[i] += pins.level[i];
		end
		for (i = 0; i < 16; i++)
			chk(hc[i], oe[i] ? (pol[i] ? 512 - 2 * duty[i] : 2 * duty[i]) : 512 * lvl[i]);
		note("half rate");
		sb(1'b0);
		rchk(sctpwm_pkg::IDX_DUTY_BASE + 16'h1, 0);
		rchk(sctpwm_pkg::IDX_POL_LO, pol[7:0]);
		sb(1'b1);
		rchk(sctpwm_pkg::IDX_POL_HI, 0);
		rchk(sctpwm_pkg::IDX_OE_HI, 0);
		note("standby");
		print_verdict();
	end
endmodule
